// file: alsu_core.sv
/*
 * Arithmetic, logic and shift execution unit of an 8/16-bit CPU core.
 * Takes one operation per request, returns result and flags one cycle
 * later, or eighteen cycles later for a division.
 * Assumes the register file supplies operands and applies the write
 * back and the flags when done_out is high.
 */
`timescale 1ns/10ps
`include "alsu_defs.svh"

module alsu_core (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic req_valid_in,
	output logic ready_out,
	input wire alsu_pkg::alsu_op_t op_in,
	input wire logic word_size_in,
	input wire logic use_imm_in,
	input wire logic [15:0] dst_value_in,
	input wire logic [15:0] src_register_in,
	input wire logic [7:0] imm_in,
	input wire logic [`ALSU_FLAGS_W-1:0] condition_flags_in,
	output logic done_out,
	output logic [15:0] result_out,
	output logic result_wr_out,
	output logic result_word_out,
	output logic [`ALSU_FLAGS_W-1:0] condition_flags_out,
	output logic illegal_out
);

	alsu_pkg::alsu_regs_t cur_r;
	alsu_pkg::alsu_regs_t cur_nxt;
	logic div_start;
	logic div_done;
	logic [7:0] div_quot;
	logic [7:0] div_rem;
	logic acc;

	function automatic logic op_legal(input alsu_pkg::alsu_op_t op,
		input logic word, input logic imm);
		logic ok;
		ok = 1'b1;
		if (imm) begin
			case (op)
				alsu_pkg::op_add: ok = !word;
				alsu_pkg::op_compare_op: ok = !word;
				alsu_pkg::op_add_with_carry,
				alsu_pkg::op_subtract_with_borrow,
				alsu_pkg::op_and,
				alsu_pkg::op_or,
				alsu_pkg::op_xor: ok = 1'b1;
				default: ok = 1'b0;
			endcase
		end
		return ok;
	endfunction

	// Adder for every add, subtract, compare and negate
	function automatic alsu_pkg::alsu_arith_t arith(input logic [15:0] a,
		input logic [15:0] b, input logic sub, input logic cin,
		input logic word);
		logic [15:0] bb;
		logic [16:0] s16;
		logic [8:0] s8;
		logic [4:0] h4;
		logic [12:0] h12;
		logic msb_a;
		logic msb_b;
		logic msb_r;
		alsu_pkg::alsu_arith_t r;
		bb = sub ? ~b : b;
		s16 = {1'b0, a} + {1'b0, bb} + {16'h0000, cin};
		s8 = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + {8'h00, cin};
		h4 = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
		h12 = {1'b0, a[11:0]} + {1'b0, bb[11:0]} + {12'h000, cin};
		r.res = word ? s16[15:0] : {8'h00, s8[7:0]};
		// Carry out of a subtract is the inverted borrow
		r.c = (word ? s16[16] : s8[8]) ^ sub;
		r.h = (word ? h12[12] : h4[4]) ^ sub;
		msb_a = word ? a[15] : a[7];
		msb_b = word ? bb[15] : bb[7];
		msb_r = word ? s16[15] : s8[7];
		r.v = (msb_a == msb_b) && (msb_r != msb_a);
		return r;
	endfunction

	assign acc = req_valid_in && ready_out;
	assign div_start = acc && (op_in == alsu_pkg::op_unsigned_divide) &&
		op_legal(op_in, word_size_in, use_imm_in);

	always_comb begin
		logic [15:0] opb;
		logic [15:0] res;
		logic [7:0] a;
		logic [7:0] adj;
		logic [`ALSU_FLAGS_W-1:0] f;
		logic fc;
		logic fv;
		logic fh;
		logic wd;
		logic use_ar;
		logic keep_c;
		logic hi;
		logic lo;
		alsu_pkg::alsu_arith_t ar;
		a = dst_value_in[7:0];
		f = condition_flags_in;
		opb = use_imm_in ? {8'h00, imm_in} : src_register_in;
		res = 16'h0000;
		adj = 8'h00;
		fc = f[`ALSU_FLAG_C];
		fv = 1'b0;
		fh = f[`ALSU_FLAG_H];
		wd = 1'b0;
		use_ar = 1'b0;
		keep_c = 1'b0;
		hi = 1'b0;
		lo = 1'b0;
		ar = arith(dst_value_in, opb, 1'b0, 1'b0, 1'b0);
		cur_nxt = cur_r;
		cur_nxt.done = 1'b0;
		cur_nxt.wr = 1'b0;
		cur_nxt.illegal = 1'b0;
		unique case (cur_r.st)
			alsu_pkg::st_idle: if (req_valid_in) begin
				cur_nxt.done = 1'b1;
				cur_nxt.wr = 1'b1;
				cur_nxt.last_div = 1'b0;
				if (!op_legal(op_in, word_size_in, use_imm_in)) begin
					cur_nxt.wr = 1'b0;
					cur_nxt.illegal = 1'b1;
				end else begin
					case (op_in)
						alsu_pkg::op_add: begin
							ar = arith(dst_value_in, opb, 1'b0, 1'b0, word_size_in);
							wd = word_size_in;
							use_ar = 1'b1;
						end
						alsu_pkg::op_sub: begin
							ar = arith(dst_value_in, opb, 1'b1, 1'b1, word_size_in);
							wd = word_size_in;
							use_ar = 1'b1;
						end
						alsu_pkg::op_add_with_carry: begin
							ar = arith(dst_value_in, opb, 1'b0, f[`ALSU_FLAG_C], 1'b0);
							use_ar = 1'b1;
						end
						alsu_pkg::op_subtract_with_borrow: begin
							ar = arith(dst_value_in, opb, 1'b1, !f[`ALSU_FLAG_C], 1'b0);
							use_ar = 1'b1;
						end
						alsu_pkg::op_inc: begin
							ar = arith(dst_value_in, 16'h0001, 1'b0, 1'b0, 1'b0);
							use_ar = 1'b1;
							keep_c = 1'b1;
						end
						alsu_pkg::op_dec: begin
							ar = arith(dst_value_in, 16'h0001, 1'b1, 1'b1, 1'b0);
							use_ar = 1'b1;
							keep_c = 1'b1;
						end
						alsu_pkg::op_add_small_const: begin
							// imm_in bit 1 selects a constant of two
							ar = arith(dst_value_in, imm_in[1] ? 16'h0002 : 16'h0001,
								1'b0, 1'b0, 1'b1);
							wd = 1'b1;
							use_ar = 1'b1;
						end
						alsu_pkg::op_sub_small_const: begin
							ar = arith(dst_value_in, imm_in[1] ? 16'h0002 : 16'h0001,
								1'b1, 1'b1, 1'b1);
							wd = 1'b1;
							use_ar = 1'b1;
						end
						alsu_pkg::op_decimal_adjust_add: begin
							lo = f[`ALSU_FLAG_H] || (a[3:0] > 4'h9);
							hi = f[`ALSU_FLAG_C] || (a > 8'h99);
							adj = {hi ? 4'h6 : 4'h0, lo ? 4'h6 : 4'h0};
							res = {8'h00, a + adj};
							fc = hi;
						end
						alsu_pkg::op_decimal_adjust_sub: begin
							adj = {f[`ALSU_FLAG_C] ? 4'h6 : 4'h0,
								f[`ALSU_FLAG_H] ? 4'h6 : 4'h0};
							res = {8'h00, a - adj};
						end
						alsu_pkg::op_unsigned_multiply: begin
							res = {8'h00, a} * {8'h00, src_register_in[7:0]};
							wd = 1'b1;
							fc = 1'b0;
						end
						alsu_pkg::op_unsigned_divide: begin
							cur_nxt.st = alsu_pkg::st_divide;
							cur_nxt.done = 1'b0;
							cur_nxt.wr = 1'b0;
							cur_nxt.dividend = dst_value_in;
							cur_nxt.divisor = src_register_in[7:0];
						end
						alsu_pkg::op_compare_op: begin
							ar = arith(dst_value_in, opb, 1'b1, 1'b1, word_size_in);
							wd = word_size_in;
							use_ar = 1'b1;
							cur_nxt.wr = 1'b0;
						end
						alsu_pkg::op_twos_complement_op: begin
							ar = arith(16'h0000, dst_value_in, 1'b1, 1'b1, 1'b0);
							use_ar = 1'b1;
						end
						alsu_pkg::op_and: res = {8'h00, a & opb[7:0]};
						alsu_pkg::op_or: res = {8'h00, a | opb[7:0]};
						alsu_pkg::op_xor: res = {8'h00, a ^ opb[7:0]};
						alsu_pkg::op_not: res = {8'h00, ~a};
						alsu_pkg::op_arith_shift_left: begin
							res = {8'h00, a[6:0], 1'b0};
							fc = a[7];
							fv = a[7] ^ a[6];
						end
						alsu_pkg::op_arith_shift_right: begin
							res = {8'h00, a[7], a[7:1]};
							fc = a[0];
						end
						alsu_pkg::op_logic_shift_left: begin
							res = {8'h00, a[6:0], 1'b0};
							fc = a[7];
						end
						alsu_pkg::op_logic_shift_right: begin
							res = {8'h00, 1'b0, a[7:1]};
							fc = a[0];
						end
						alsu_pkg::op_rotate_left: begin
							res = {8'h00, a[6:0], a[7]};
							fc = a[7];
						end
						alsu_pkg::op_rotate_right: begin
							res = {8'h00, a[0], a[7:1]};
							fc = a[0];
						end
						alsu_pkg::op_rotate_left_through_carry: begin
							res = {8'h00, a[6:0], f[`ALSU_FLAG_C]};
							fc = a[7];
						end
						alsu_pkg::op_rotate_right_through_carry: begin
							res = {8'h00, f[`ALSU_FLAG_C], a[7:1]};
							fc = a[0];
						end
						default: begin
							cur_nxt.wr = 1'b0;
							cur_nxt.illegal = 1'b1;
						end
					endcase
					if (use_ar) begin
						res = ar.res;
						fv = ar.v;
						fh = ar.h;
						if (!keep_c) begin
							fc = ar.c;
						end
					end
					// Flag update, held back on a pending division
					if (!div_start && !cur_nxt.illegal) begin
						f[`ALSU_FLAG_N] = wd ? res[15] : res[7];
						f[`ALSU_FLAG_Z] = wd ? (res == 16'h0000) : (res[7:0] == 8'h00);
						f[`ALSU_FLAG_V] = fv;
						f[`ALSU_FLAG_C] = fc;
						f[`ALSU_FLAG_H] = fh;
					end
					cur_nxt.result = res;
				end
				cur_nxt.flags = f;
				cur_nxt.word = wd;
			end
			alsu_pkg::st_divide: if (div_done) begin
				cur_nxt.st = alsu_pkg::st_idle;
				cur_nxt.done = 1'b1;
				cur_nxt.wr = 1'b1;
				cur_nxt.word = 1'b1;
				cur_nxt.last_div = 1'b1;
				// Remainder in the upper byte, quotient in the lower
				if (cur_r.divisor == 8'h00) begin
					cur_nxt.result = {cur_r.dividend[7:0], `ALSU_DIV0_QUOT};
				end else begin
					cur_nxt.result = {div_rem, div_quot};
				end
				cur_nxt.flags[`ALSU_FLAG_N] = cur_nxt.result[7];
				cur_nxt.flags[`ALSU_FLAG_Z] = (cur_r.divisor == 8'h00);
				cur_nxt.flags[`ALSU_FLAG_V] = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cur_r <= '0;
			cur_r.st <= alsu_pkg::st_idle;
			cur_r.result <= `ALSU_RESULT_RST;
			cur_r.flags <= `ALSU_FLAGS_RST;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	alsu_divider u_divider (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.start_in(div_start),
		.dividend_in(dst_value_in),
		.divisor_in(src_register_in[7:0]),
		.done_out(div_done),
		.quotient_out(div_quot),
		.remainder_out(div_rem)
	);

	assign ready_out = (cur_r.st == alsu_pkg::st_idle);
	assign done_out = cur_r.done;
	assign result_out = cur_r.result;
	assign result_wr_out = cur_r.wr;
	assign result_word_out = cur_r.word;
	assign condition_flags_out = cur_r.flags;
	assign illegal_out = cur_r.illegal;

	property p_sub_imm;
		@(posedge clk_in) disable iff (rst_in)
		acc && op_in == alsu_pkg::op_sub && use_imm_in
		|=> done_out && illegal_out && !result_wr_out;
	endproperty
	a_sub_imm: assert property (p_sub_imm) else $error("imm sub taken");

	property p_word_imm;
		@(posedge clk_in) disable iff (rst_in)
		acc && op_in == alsu_pkg::op_add && use_imm_in && word_size_in
		|=> illegal_out && !result_wr_out;
	endproperty
	a_word_imm: assert property (p_word_imm) else $error("word imm add");

	property p_add_with_carry;
		@(posedge clk_in) disable iff (rst_in)
		acc && op_in == alsu_pkg::op_add_with_carry && !use_imm_in &&
		condition_flags_in[`ALSU_FLAG_C]
		|=> result_wr_out && result_out == (16'h00ff &
			($past(dst_value_in) + $past(src_register_in) + 16'h0001));
	endproperty
	a_add_with_carry: assert property (p_add_with_carry) else $error("carry add wrong");

	property p_inc;
		@(posedge clk_in) disable iff (rst_in)
		acc && op_in == alsu_pkg::op_inc && !use_imm_in
		|=> result_out == (16'h00ff & ($past(dst_value_in) + 16'h0001)) &&
			condition_flags_out[`ALSU_FLAG_C] ==
			$past(condition_flags_in[`ALSU_FLAG_C]);
	endproperty
	a_inc: assert property (p_inc) else $error("increment wrong");

	property p_small;
		@(posedge clk_in) disable iff (rst_in)
		acc && op_in == alsu_pkg::op_add_small_const && !use_imm_in
		|=> result_word_out && (result_out == $past(dst_value_in) +
			($past(imm_in[1]) ? 16'h0002 : 16'h0001));
	endproperty
	a_small: assert property (p_small) else $error("small add wrong");

	property p_mul;
		@(posedge clk_in) disable iff (rst_in)
		acc && op_in == alsu_pkg::op_unsigned_multiply && !use_imm_in
		|=> result_out == ((16'h00ff & $past(dst_value_in)) *
			(16'h00ff & $past(src_register_in)));
	endproperty
	a_mul: assert property (p_mul) else $error("product wrong");

	property p_div_time;
		@(posedge clk_in) disable iff (rst_in)
		div_start |=> !ready_out[*8] ##10 done_out && result_wr_out;
	endproperty
	a_div_time: assert property (p_div_time) else $error("divide late");

	property p_div_val;
		@(posedge clk_in) disable iff (rst_in)
		done_out && cur_r.last_div && cur_r.divisor != 8'h00
		|-> result_out[7:0] == 8'(cur_r.dividend / {8'h00, cur_r.divisor}) &&
			result_out[15:8] == 8'(cur_r.dividend % {8'h00, cur_r.divisor});
	endproperty
	a_div_val: assert property (p_div_val) else $error("divide wrong");

	property p_cmp;
		@(posedge clk_in) disable iff (rst_in)
		acc && op_in == alsu_pkg::op_compare_op && !use_imm_in
		|=> done_out && !result_wr_out && !illegal_out;
	endproperty
	a_cmp: assert property (p_cmp) else $error("compare wrote");

	property p_cmp_imm;
		@(posedge clk_in) disable iff (rst_in)
		acc && op_in == alsu_pkg::op_compare_op && use_imm_in && word_size_in
		|=> illegal_out;
	endproperty
	a_cmp_imm: assert property (p_cmp_imm) else $error("word imm compare");

	property p_neg;
		@(posedge clk_in) disable iff (rst_in)
		acc && op_in == alsu_pkg::op_twos_complement_op && !use_imm_in
		|=> result_out == (16'h00ff & (16'h0000 - $past(dst_value_in)));
	endproperty
	a_neg: assert property (p_neg) else $error("negate wrong");

	property p_arith_shift_right;
		@(posedge clk_in) disable iff (rst_in)
		acc && op_in == alsu_pkg::op_arith_shift_right && !use_imm_in
		|=> result_out == (((16'h00ff & $past(dst_value_in)) >> 1) |
			(16'h0080 & $past(dst_value_in)));
	endproperty
	a_arith_shift_right: assert property (p_arith_shift_right) else $error("sign lost");

	property p_rotate_left_through_carry;
		@(posedge clk_in) disable iff (rst_in)
		acc && op_in == alsu_pkg::op_rotate_left_through_carry &&
		!use_imm_in && !condition_flags_in[`ALSU_FLAG_C] && dst_value_in[7]
		|=> condition_flags_out[`ALSU_FLAG_C] &&
			result_out == (16'h00fe & ($past(dst_value_in) << 1));
	endproperty
	a_rotate_left_through_carry: assert property (p_rotate_left_through_carry) else $error("carry rotate");

	property p_logic_c;
		@(posedge clk_in) disable iff (rst_in)
		acc && op_in == alsu_pkg::op_and && condition_flags_in[`ALSU_FLAG_C]
		|=> condition_flags_out[`ALSU_FLAG_C] &&
			!condition_flags_out[`ALSU_FLAG_V];
	endproperty
	a_logic_c: assert property (p_logic_c) else $error("carry changed");

endmodule

// file: alsu_defs.svh
/*
 * Constants of the arithmetic, logic and shift unit: flag bit positions,
 * reset values and divider timing.
 * Assumes it is included by bare name by the package and the modules.
 */
`ifndef ALSU_DEFS_SVH
`define ALSU_DEFS_SVH

`define ALSU_FLAG_C 0
`define ALSU_FLAG_V 1
`define ALSU_FLAG_Z 2
`define ALSU_FLAG_N 3
`define ALSU_FLAG_H 4
`define ALSU_FLAGS_W 5

`define ALSU_FLAGS_RST 5'h00
`define ALSU_RESULT_RST 16'h0000
`define ALSU_DIV_STEPS 5'h10
`define ALSU_DIV0_QUOT 8'hff

`endif

// file: alsu_pkg.sv
/*
 * Types of the arithmetic, logic and shift unit: operation codes,
 * sequencer states and the packed state of each module.
 * Assumes alsu_defs.svh is on the include path.
 */
`include "alsu_defs.svh"

package alsu_pkg;

	typedef enum logic [4:0] {
		op_add = 5'b00000,
		op_sub = 5'b00001,
		op_add_with_carry = 5'b00010,
		op_subtract_with_borrow = 5'b00011,
		op_inc = 5'b00100,
		op_dec = 5'b00101,
		op_add_small_const = 5'b00110,
		op_sub_small_const = 5'b00111,
		op_decimal_adjust_add = 5'b01000,
		op_decimal_adjust_sub = 5'b01001,
		op_unsigned_multiply = 5'b01010,
		op_unsigned_divide = 5'b01011,
		op_compare_op = 5'b01100,
		op_twos_complement_op = 5'b01101,
		op_and = 5'b01110,
		op_or = 5'b01111,
		op_xor = 5'b10000,
		op_not = 5'b10001,
		op_arith_shift_left = 5'b10010,
		op_arith_shift_right = 5'b10011,
		op_logic_shift_left = 5'b10100,
		op_logic_shift_right = 5'b10101,
		op_rotate_left = 5'b10110,
		op_rotate_right = 5'b10111,
		op_rotate_left_through_carry = 5'b11000,
		op_rotate_right_through_carry = 5'b11001
	} alsu_op_t;

	typedef enum logic [0:0] {
		st_idle = 1'b0,
		st_divide = 1'b1
	} alsu_state_t;

	typedef struct packed {
		logic [15:0] res;
		logic c;
		logic v;
		logic h;
	} alsu_arith_t;

	typedef struct packed {
		alsu_state_t st;
		logic [15:0] result;
		logic [`ALSU_FLAGS_W-1:0] flags;
		logic done;
		logic wr;
		logic word;
		logic illegal;
		logic last_div;
		logic [15:0] dividend;
		logic [7:0] divisor;
	} alsu_regs_t;

	typedef struct packed {
		logic busy;
		logic done;
		logic [4:0] count;
		logic [7:0] rem;
		logic [15:0] quot;
		logic [7:0] divisor;
	} alsu_div_regs_t;

endpackage

// file: alsu_divider.sv
/*
 * Restoring 16 by 8 bit unsigned divider, one quotient bit per cycle.
 * Assumes start_in is a one-cycle pulse while the divider is idle and
 * that the caller handles a zero divisor.
 */
`timescale 1ns/10ps
`include "alsu_defs.svh"

module alsu_divider (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic start_in,
	input wire logic [15:0] dividend_in,
	input wire logic [7:0] divisor_in,
	output logic done_out,
	output logic [7:0] quotient_out,
	output logic [7:0] remainder_out
);

	alsu_pkg::alsu_div_regs_t cur_r;
	alsu_pkg::alsu_div_regs_t cur_nxt;

	always_comb begin
		logic [8:0] trial;
		logic fits;
		trial = {cur_r.rem, cur_r.quot[15]};
		fits = (trial >= {1'b0, cur_r.divisor});
		cur_nxt = cur_r;
		cur_nxt.done = 1'b0;
		if (start_in) begin
			cur_nxt.busy = 1'b1;
			cur_nxt.count = `ALSU_DIV_STEPS;
			cur_nxt.rem = 8'h00;
			cur_nxt.quot = dividend_in;
			cur_nxt.divisor = divisor_in;
		end else if (cur_r.busy) begin
			// Shift in one dividend bit, keep the difference if it fits
			cur_nxt.rem = fits ? 8'(trial - {1'b0, cur_r.divisor}) : trial[7:0];
			cur_nxt.quot = {cur_r.quot[14:0], fits};
			cur_nxt.count = cur_r.count - 5'h01;
			if (cur_r.count == 5'h01) begin
				cur_nxt.busy = 1'b0;
				cur_nxt.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cur_r <= '0;
		end else begin
			cur_r <= cur_nxt;
		end
	end

	assign done_out = cur_r.done;
	assign quotient_out = cur_r.quot[7:0];
	assign remainder_out = cur_r.rem;

endmodule

// file: test_cpu_arith_logic_shift_unit.sv
/*
 * Self-checking bench of the arithmetic, logic and shift unit: random and
 * edge-case requests, every written result compared with a reference model.
 * Assumes alsu_pkg and alsu_core are compiled before it.
 */
`timescale 1ns/10ps

module test_cpu_arith_logic_shift_unit;
	typedef struct {
		logic [15:0] r;
		logic [4:0] f;
		logic [4:0] m;
		logic wr;
		logic wd;
		logic il;
		int due;
	} alsu_exp_t;

	logic clk_in, rst_in, req_valid_in, word_size_in, use_imm_in;
	alsu_pkg::alsu_op_t op_in;
	logic [15:0] dst_value_in, src_register_in, result_out;
	logic [7:0] imm_in;
	logic [4:0] condition_flags_in, condition_flags_out;
	logic ready_out, done_out, result_wr_out, result_word_out, illegal_out;
	int mismatches, n_compared, cyc, rdy_at;
	bit hold;
	alsu_exp_t expq[$];

	alsu_core dut (.clk_in(clk_in), .rst_in(rst_in),
		.req_valid_in(req_valid_in), .ready_out(ready_out), .op_in(op_in),
		.word_size_in(word_size_in), .use_imm_in(use_imm_in),
		.dst_value_in(dst_value_in), .src_register_in(src_register_in),
		.imm_in(imm_in), .condition_flags_in(condition_flags_in),
		.done_out(done_out), .result_out(result_out),
		.result_wr_out(result_wr_out), .result_word_out(result_word_out),
		.condition_flags_out(condition_flags_out), .illegal_out(illegal_out));

	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	always @(posedge clk_in) cyc <= cyc + 1;

	task automatic test_done;
		if (mismatches == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Flags {H,N,Z,V,C}; borrow shows as C for subtracts
	function automatic void arith(input int a, input int b, input int cin,
		input bit word, input bit sub, output logic [15:0] r,
		output logic [4:0] f);
		int m, hm, s, hs;
		bit sa, sb, sr;
		m = word ? 'hffff : 'hff;
		hm = word ? 'hfff : 'hf;
		s = sub ? (a & m) - (b & m) - cin : (a & m) + (b & m) + cin;
		hs = sub ? (a & hm) - (b & hm) - cin : (a & hm) + (b & hm) + cin;
		r = s & m;
		sa = word ? a[15] : a[7];
		sb = word ? b[15] : b[7];
		sr = word ? r[15] : r[7];
		f = {sub ? hs < 0 : hs > hm, sr, r == 16'h0000,
			(sub ? sa != sb : sa == sb) && sr != sa, sub ? s < 0 : s > m};
	endfunction

	task automatic model(output alsu_exp_t e);
		int a, b;
		logic [7:0] x, y, q, d;
		logic [4:0] o;
		logic c, hf, hi, co, v, lg, sb;
		o = op_in;
		a = dst_value_in;
		b = use_imm_in ? imm_in : src_register_in;
		x = dst_value_in[7:0];
		d = src_register_in[7:0];
		c = condition_flags_in[0];
		hf = condition_flags_in[4];
		hi = c || x > 8'h99;
		y = x;
		e.r = 16'h0000;
		e.f = condition_flags_in;
		e.m = 5'h1f;
		e.due = 0;
		// Subtracting codes: sub, borrow, dec, small sub, compare, negate
		sb = o inside {5'h01, 5'h03, 5'h05, 5'h07, 5'h0c, 5'h0d};
		case (op_in)
			alsu_pkg::op_add, alsu_pkg::op_sub, alsu_pkg::op_compare_op:
				arith(a, b, 0, word_size_in, sb, e.r, e.f);
			alsu_pkg::op_add_with_carry, alsu_pkg::op_subtract_with_borrow:
				arith(a, b, c, 0, sb, e.r, e.f);
			alsu_pkg::op_inc, alsu_pkg::op_dec: arith(x, 1, 0, 0, sb, e.r, e.f);
			alsu_pkg::op_add_small_const, alsu_pkg::op_sub_small_const:
				arith(a, imm_in[1] ? 2 : 1, 0, 1, sb, e.r, e.f);
			alsu_pkg::op_twos_complement_op: arith(0, x, 0, 0, sb, e.r, e.f);
			alsu_pkg::op_decimal_adjust_add: y = x + (hi ? 8'h60 : 8'h00) +
				(hf || x[3:0] > 4'h9 ? 8'h06 : 8'h00);
			alsu_pkg::op_decimal_adjust_sub:
				y = x - (hf ? 8'h06 : 8'h00) - (c ? 8'h60 : 8'h00);
			alsu_pkg::op_and: y = x & b[7:0];
			alsu_pkg::op_or: y = x | b[7:0];
			alsu_pkg::op_xor: y = x ^ b[7:0];
			alsu_pkg::op_not: y = ~x;
			alsu_pkg::op_arith_shift_left, alsu_pkg::op_logic_shift_left:
				y = {x[6:0], 1'b0};
			alsu_pkg::op_arith_shift_right: y = {x[7], x[7:1]};
			alsu_pkg::op_logic_shift_right: y = {1'b0, x[7:1]};
			alsu_pkg::op_rotate_left: y = {x[6:0], x[7]};
			alsu_pkg::op_rotate_right: y = {x[0], x[7:1]};
			alsu_pkg::op_rotate_left_through_carry: y = {x[6:0], c};
			alsu_pkg::op_rotate_right_through_carry: y = {c, x[7:1]};
			default: ;
		endcase
		// Shift codes 18..25: even ones move left
		co = o >= 5'h12 && o <= 5'h19 ? (o[0] ? x[0] : x[7]) : c;
		if (o == 5'h08)
			co = hi;
		v = o == 5'h12 && (x[7] ^ x[6]);
		lg = o == 5'h08 || o == 5'h09 || (o >= 5'h0e && o <= 5'h19);
		if (lg) begin
			e.r = {8'h00, y};
			e.f = {hf, y[7], y == 8'h00, v, co};
		end
		if (o == 5'h04 || o == 5'h05)
			e.f[0] = c;
		if (op_in == alsu_pkg::op_unsigned_multiply) begin
			e.r = x * d;
			e.f = {1'b0, e.r[15], e.r == 16'h0000, 2'b00};
		end
		if (op_in == alsu_pkg::op_unsigned_divide) begin
			q = d == 8'h00 ? 8'hff : 8'(dst_value_in / d);
			e.r = {d == 8'h00 ? x : 8'(dst_value_in % d), q};
			e.f = {hf, q[7], d == 8'h00, 1'b0, c};
		end
		// H left open for inc, dec, decimal adjust and multiply
		e.m[4] = !(o inside {5'h04, 5'h05, 5'h08, 5'h09, 5'h0a});
		e.wr = op_in != alsu_pkg::op_compare_op;
		e.wd = o inside {5'h06, 5'h07, 5'h0a, 5'h0b} || (word_size_in && o < 5'h02);
		// Immediate only for add, carry forms, compare, and, or and xor
		e.il = o > 5'h19 || (use_imm_in && !(o inside {5'h00, 5'h02, 5'h03,
			5'h0c, 5'h0e, 5'h0f, 5'h10})) ||
			(use_imm_in && word_size_in && (o == 5'h00 || o == 5'h0c));
		if (e.il) begin
			e.wr = 1'b0;
			e.f = condition_flags_in;
		end
	endtask

	task automatic tick;
		alsu_exp_t e;
		@(negedge clk_in);
		if (!rst_in) begin
			if (expq.size() > 0 && expq[0].due == cyc) begin
				e = expq.pop_front();
				check(done_out, 1'b1);
				check(illegal_out, e.il);
				check(result_wr_out, e.wr);
				if (e.wr)
					check(result_out, e.r);
				if (e.wr)
					check(result_word_out, e.wd);
				check(condition_flags_out & e.m, e.f & e.m);
			end else begin
				check(done_out, 1'b0);
			end
			check(ready_out, cyc >= rdy_at);
			if (req_valid_in && ready_out === 1'b1) begin
				model(e);
				e.due = cyc + (op_in == alsu_pkg::op_unsigned_divide && !e.il ? 18 : 1);
				if (op_in == alsu_pkg::op_unsigned_divide && !e.il)
					rdy_at = e.due;
				expq.push_back(e);
			end
		end
		// A request met by ready low stays on the pins
		hold = req_valid_in && ready_out !== 1'b1;
	endtask

	task automatic drive(input logic [4:0] op, input logic w, input logic ui,
		input logic [15:0] a, input logic [15:0] b, input logic [7:0] im,
		input logic [4:0] fi, input logic vld);
		@(posedge clk_in);
		while (hold) begin
			tick;
			@(posedge clk_in);
		end
		rst_in <= 1'b0;
		req_valid_in <= vld;
		op_in <= alsu_pkg::alsu_op_t'(op);
		word_size_in <= w;
		use_imm_in <= ui;
		dst_value_in <= a;
		src_register_in <= b;
		imm_in <= im;
		condition_flags_in <= fi;
		tick;
	endtask

	task automatic rnd;
		logic [15:0] a, b;
		logic [4:0] op;
		op = 5'($urandom);
		a = 16'($urandom);
		b = 16'($urandom);
		// Keep the quotient within eight bits
		if (op == 5'h0b && b[7:0] != 8'h00)
			a[15:8] = a[15:8] % b[7:0];
		drive(op, 1'($urandom), 1'($urandom), a, b, 8'($urandom), 5'($urandom),
			$urandom_range(0, 7) != 0);
	endtask

	task automatic do_reset;
		@(posedge clk_in);
		rst_in <= 1'b1;
		req_valid_in <= 1'b0;
		repeat (11) @(posedge clk_in);
		@(negedge clk_in);
		check({done_out, result_wr_out, illegal_out, ready_out}, 4'h1);
		check(result_out, 16'h0000);
		check(condition_flags_out, 5'h00);
		expq.delete();
		rdy_at = 0;
		hold = 1'b0;
	endtask

	initial begin
		#100000;
		mismatches++;
		test_done;
	end

	initial begin
		{rst_in, req_valid_in, word_size_in, use_imm_in} = 4'h8;
		op_in = alsu_pkg::op_add;
		{dst_value_in, src_register_in, imm_in, condition_flags_in} = 45'h0;
		{mismatches, n_compared, cyc, rdy_at} = 128'h0;
		void'($urandom(32'h8a0451c9));
		do_reset;
		drive(5'h00, 1'b1, 1'b0, 16'hffff, 16'h0001, 8'h00, 5'h00, 1'b1);
		drive(5'h01, 1'b0, 1'b1, 16'h0010, 16'h0000, 8'h01, 5'h0f, 1'b1);
		drive(5'h0c, 1'b1, 1'b1, 16'h1234, 16'h0000, 8'h34, 5'h00, 1'b1);
		drive(5'h07, 1'b0, 1'b0, 16'h0001, 16'h0000, 8'h02, 5'h00, 1'b1);
		drive(5'h0a, 1'b0, 1'b0, 16'h00ff, 16'h00ff, 8'h00, 5'h00, 1'b1);
		drive(5'h0b, 1'b0, 1'b0, 16'h1234, 16'h0000, 8'h00, 5'h00, 1'b1);
		repeat (18) drive(5'h0b, 1'b0, 1'b0, 16'hfe01, 16'h00ff, 8'h00, 5'h00, 1'b1);
		drive(5'h1f, 1'b0, 1'b0, 16'h0055, 16'h0000, 8'h00, 5'h1f, 1'b1);
		repeat (3000) rnd;
		do_reset;
		repeat (1500) rnd;
		repeat (20) drive(5'h00, 1'b0, 1'b0, 16'h0000, 16'h0000, 8'h00, 5'h00, 1'b0);
		test_done;
	end
endmodule
